// *** design/evt_tmr_defs.vh ***
/*
 * Constants for the event counter and microsecond timer: register offsets,
 * field positions, reset values, selector encodings and timing counts.
 * Assumes it is included by bare name from the design files.
 */
`ifndef EVT_TMR_DEFS_VH
`define EVT_TMR_DEFS_VH

// Register offsets on the plain register port (word index).
`define REG_CTRL           4'h0
`define REG_TMR_SRC        4'h1
`define REG_TMR_LEN        4'h2
`define REG_TMR_VAL        4'h3
`define REG_TMR_STATE      4'h4
`define REG_CNT_LIMIT      4'h5
`define REG_CNT_VAL        4'h6
`define REG_CNT_SNAP       4'h7
`define REG_CMD            4'h8
`define REG_CNT_CFG        4'h9

// Field positions.
`define CTRL_TMR_EN        0
`define CMD_TMR_CLEAR      0
`define CMD_CNT_CLEAR      1
`define CNT_CFG_RUN        2

// Reset values.
`define TMR_LEN_RST        32'h0000_0001
`define CNT_LIMIT_RST      32'h0000_0001

// Edge selections.
`define EDGE_RISE          2'h0
`define EDGE_FALL          2'h1
`define EDGE_ANY           2'h2

// Timer launch sources.
`define SRC_OFF            5'h00
`define SRC_ACQ_START      5'h01
`define SRC_ACQ_END        5'h02
`define SRC_EXP_START      5'h03
`define SRC_EXP_END        5'h04
`define SRC_RD_START       5'h05
`define SRC_RD_END         5'h06
`define SRC_FRAME_START    5'h07
`define SRC_FRAME_TRIG     5'h08
`define SRC_BURST_END      5'h09
`define SRC_ACTION_ONE     5'h0A
`define SRC_ACTION_TWO     5'h0B
`define SRC_PIN_ONE        5'h0C
`define SRC_PIN_TWO        5'h0D
`define SRC_TMR_END        5'h0E
`define SRC_CYCLE_FIRST    5'h0F
`define SRC_CNT_END        5'h10

// Timer state readback codes.
`define TST_IDLE           2'h0
`define TST_ARMED          2'h1
`define TST_RUNNING        2'h2
`define TST_DONE           2'h3

// Timing: clock rate and the microsecond tick derived from it.
`define SYS_CLK_HZ         50000000
`define TICK_TIME_US       1
`define TICK_CYCLES        ((`SYS_CLK_HZ / 1000000) * `TICK_TIME_US)

`endif

// *** design/us_tick_gen.v ***
/*
 * Prescaler that produces a one-cycle enable once per microsecond.
 * Assumes a single system clock at the rate given in the constants header.
 */
`include "evt_tmr_defs.vh"

module us_tick_gen
(
	// Clock and reset.
	input  wire        sys_clk,
	input  wire        rst_n,
	// Tick output.
	output reg         tick
);

	// The count is cut to the divider width on purpose; it fits easily.
	localparam integer LAST_INT = `TICK_CYCLES - 1;
	localparam [7:0]   LAST     = LAST_INT[7:0];

	reg [7:0] div_reg;

	////////////////////////////////////////////////////////////////////////////
	// Free-running divider; the tick is registered so it never glitches.
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			div_reg <= 8'h00;
			tick    <= 1'b0;
		end
		else if (div_reg == LAST)
		begin
			div_reg <= 8'h00;
			tick    <= 1'b1;
		end
		else
		begin
			div_reg <= div_reg + 8'h01;
			tick    <= 1'b0;
		end
	end

endmodule

// *** design/event_counter_timer.v ***
/*
 * Event counter tail features and a single microsecond timer with a
 * register port. Event inputs are one-cycle pulses from logic on sys_clk;
 * the two input pins are asynchronous and are synchronised here.
 */
// The strobed register port and the register addresses were decided locally.
`include "evt_tmr_defs.vh"

module event_counter_timer
(
	// Clock and reset.
	input  wire        sys_clk,
	input  wire        rst_n,
	// Register port.
	input  wire [3:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	// Camera events, one-cycle pulses on sys_clk, plus the cycling active-set and first-frame levels.
	input  wire        acq_start_evt,
	input  wire        acq_end_evt,
	input  wire        exp_start_evt,
	input  wire        exp_end_evt,
	input  wire        rd_start_evt,
	input  wire        rd_end_evt,
	input  wire        frame_start_evt,
	input  wire        accepted_frame_trigger,
	input  wire        multi_frame_end_event,
	input  wire        broadcast_action_one,
	input  wire        broadcast_action_two,
	input  wire [3:0]  cycle_active_set,
	input  wire        cycle_first_frame,
	// Counter increment and clear event sources, chosen outside.
	input  wire        count_inc_evt,
	input  wire        count_clear_evt,
	// Asynchronous input pins.
	input  wire        input_pin_one,
	input  wire        input_pin_two,
	// Outputs.
	output reg         tmr_pulse_out,
	output reg         count_end_event,
	output reg         first_tmr_end_event
);

	////////////////////////////////////////////////////////////////////////////
	// Edge detector shared by counter clear and timer launch.
	function edge_hit;
		input [1:0] sel;
		input       now;
		input       was;
		begin
			case (sel)
				`EDGE_RISE: edge_hit = now & ~was;
				`EDGE_FALL: edge_hit = ~now & was;
				`EDGE_ANY:  edge_hit = now ^ was;
				default:    edge_hit = 1'b0;
			endcase
		end
	endfunction

	localparam [1:0] CNT_SRC_EVT  = 2'h0;
	localparam [1:0] CNT_SRC_PIN1 = 2'h1;
	localparam [1:0] CNT_SRC_PIN2 = 2'h2;
	localparam [1:0] CNT_SRC_SELF = 2'h3;

	// Configuration registers.
	reg        tmr_enable_setting;
	reg [4:0]  tmr_launch_source_select;
	reg [1:0]  tmr_launch_edge_select;
	reg [31:0] tmr_pulse_length_us;
	reg [31:0] count_end_limit;
	reg [1:0]  count_clear_edge_select;
	reg [1:0]  count_clear_source_select;
	reg        count_run_reg;

	// Live state.
	reg [1:0]  tmr_state_reg;
	reg [31:0] tmr_value_reg;
	reg [31:0] count_value_reg;
	reg [31:0] count_snap_reg;

	// Pin synchronisers and edge history.
	reg [1:0]  pin1_sync;
	reg [1:0]  pin2_sync;
	reg        pin1_last;
	reg        pin2_last;

	wire tick;

	us_tick_gen u_tick
	(
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.tick    (tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers; only the second stage is seen by edge logic.
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			pin1_sync <= 2'h0;
			pin2_sync <= 2'h0;
			pin1_last <= 1'b0;
			pin2_last <= 1'b0;
		end
		else
		begin
			pin1_sync <= {pin1_sync[0], input_pin_one};
			pin2_sync <= {pin2_sync[0], input_pin_two};
			pin1_last <= pin1_sync[1];
			pin2_last <= pin2_sync[1];
		end
	end

	// Command strobes from the register port.
	wire cmd_wr        = reg_wr && (reg_addr == `REG_CMD);
	wire tmr_clear_cmd = cmd_wr && reg_wdata[`CMD_TMR_CLEAR];
	wire cnt_clear_cmd = cmd_wr && reg_wdata[`CMD_CNT_CLEAR];

	// Pin edge hits for counter clearing and timer launch.
	wire p1_clr = edge_hit(count_clear_edge_select, pin1_sync[1], pin1_last);
	wire p2_clr = edge_hit(count_clear_edge_select, pin2_sync[1], pin2_last);
	wire p1_tl  = edge_hit(tmr_launch_edge_select, pin1_sync[1], pin1_last);
	wire p2_tl  = edge_hit(tmr_launch_edge_select, pin2_sync[1], pin2_last);

	////////////////////////////////////////////////////////////////////////////
	// Counter end and clear conditions.
	wire cnt_at_end = count_run_reg && count_inc_evt &&
	                  (count_value_reg + 32'h1 >= count_end_limit);

	reg src_clear;
	always @*
	begin
		case (count_clear_source_select)
			CNT_SRC_EVT:  src_clear = count_clear_evt;
			CNT_SRC_PIN1: src_clear = p1_clr;
			CNT_SRC_PIN2: src_clear = p2_clr;
			CNT_SRC_SELF: src_clear = cnt_at_end;
			default:      src_clear = 1'b0;
		endcase
	end

	// Counter: command clear restarts at once, source clear halts, self clear
	// keeps going so a self-sourced counter wraps.
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			count_value_reg <= 32'h0000_0000;
			count_snap_reg  <= 32'h0000_0000;
			count_run_reg   <= 1'b0;
			count_end_event <= 1'b0;
		end
		else
		begin
			count_end_event <= cnt_at_end;
			if (cnt_clear_cmd)
			begin
				count_snap_reg  <= count_value_reg;
				count_value_reg <= 32'h0000_0000;
				count_run_reg   <= 1'b1;
			end
			else if (src_clear)
			begin
				count_snap_reg  <= count_value_reg;
				count_value_reg <= 32'h0000_0000;
				count_run_reg   <= (count_clear_source_select == CNT_SRC_SELF);
			end
			else if (reg_wr && reg_addr == `REG_CNT_CFG)
				count_run_reg <= reg_wdata[`CNT_CFG_RUN];
			else if (count_run_reg && count_inc_evt)
				count_value_reg <= count_value_reg + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Timer launch source multiplexer.
	reg launch_evt;
	always @*
	begin
		case (tmr_launch_source_select)
			`SRC_OFF:         launch_evt = tmr_clear_cmd;
			`SRC_ACQ_START:   launch_evt = acq_start_evt;
			`SRC_ACQ_END:     launch_evt = acq_end_evt;
			`SRC_EXP_START:   launch_evt = exp_start_evt;
			`SRC_EXP_END:     launch_evt = exp_end_evt;
			`SRC_RD_START:    launch_evt = rd_start_evt;
			`SRC_RD_END:      launch_evt = rd_end_evt;
			`SRC_FRAME_START: launch_evt = frame_start_evt;
			`SRC_FRAME_TRIG:  launch_evt = accepted_frame_trigger;
			`SRC_BURST_END:   launch_evt = multi_frame_end_event;
			`SRC_ACTION_ONE:  launch_evt = broadcast_action_one;
			`SRC_ACTION_TWO:  launch_evt = broadcast_action_two;
			`SRC_PIN_ONE:     launch_evt = p1_tl;
			`SRC_PIN_TWO:     launch_evt = p2_tl;
			`SRC_TMR_END:     launch_evt = first_tmr_end_event || tmr_clear_cmd;
			`SRC_CYCLE_FIRST: launch_evt = frame_start_evt && cycle_first_frame &&
			                               (cycle_active_set == 4'h1);
			`SRC_CNT_END:     launch_evt = count_end_event;
			default:          launch_evt = 1'b0;
		endcase
	end

	wire tmr_reach = tick && (tmr_value_reg + 32'h1 >= tmr_pulse_length_us);

	////////////////////////////////////////////////////////////////////////////
	// Timer state machine. A disabled timer sits idle; with source off it
	// never arms and reads idle until the clear command launches it.
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			tmr_state_reg       <= `TST_IDLE;
			tmr_value_reg       <= 32'h0000_0000;
			tmr_pulse_out       <= 1'b0;
			first_tmr_end_event <= 1'b0;
		end
		else
		begin
			first_tmr_end_event <= 1'b0;
			if (!tmr_enable_setting)
			begin
				tmr_state_reg <= `TST_IDLE;
				tmr_value_reg <= 32'h0000_0000;
				tmr_pulse_out <= 1'b0;
			end
			else
			begin
				case (tmr_state_reg)
					`TST_IDLE, `TST_ARMED, `TST_DONE:
					begin
						if (launch_evt)
						begin
							tmr_state_reg <= `TST_RUNNING;
							tmr_value_reg <= 32'h0000_0000;
							tmr_pulse_out <= 1'b1;
						end
						else if (tmr_state_reg == `TST_IDLE &&
						         tmr_launch_source_select != `SRC_OFF)
							tmr_state_reg <= `TST_ARMED;
						else if (tmr_state_reg == `TST_ARMED &&
						         tmr_launch_source_select == `SRC_OFF)
							tmr_state_reg <= `TST_IDLE;
					end
					`TST_RUNNING:
					begin
						// Launch events are ignored here.
						if (tmr_clear_cmd && tmr_launch_source_select != `SRC_OFF)
						begin
							tmr_value_reg <= 32'h0000_0000;
							tmr_state_reg <= `TST_ARMED;
							tmr_pulse_out <= 1'b0;
						end
						else if (tmr_reach)
						begin
							tmr_value_reg       <= tmr_pulse_length_us;
							tmr_state_reg       <= `TST_DONE;
							tmr_pulse_out       <= 1'b0;
							first_tmr_end_event <= 1'b1;
						end
						else if (tick)
							tmr_value_reg <= tmr_value_reg + 32'h0000_0001;
					end
					default: tmr_state_reg <= `TST_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register writes. Timer settings are locked while the timer is enabled,
	// so a running pulse cannot change length under its own feet.
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			tmr_enable_setting        <= 1'b0;
			tmr_launch_source_select  <= `SRC_OFF;
			tmr_launch_edge_select    <= `EDGE_RISE;
			tmr_pulse_length_us       <= `TMR_LEN_RST;
			count_end_limit           <= `CNT_LIMIT_RST;
			count_clear_edge_select   <= `EDGE_RISE;
			count_clear_source_select <= CNT_SRC_EVT;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				`REG_CTRL: tmr_enable_setting <= reg_wdata[`CTRL_TMR_EN];
				`REG_TMR_SRC:
				begin
					if (!tmr_enable_setting)
					begin
						tmr_launch_source_select <= reg_wdata[4:0];
						tmr_launch_edge_select   <= reg_wdata[9:8];
					end
				end
				`REG_TMR_LEN:
				begin
					if (!tmr_enable_setting)
						tmr_pulse_length_us <= reg_wdata;
				end
				`REG_CNT_LIMIT: count_end_limit <= reg_wdata;
				`REG_CNT_CFG:
				begin
					count_clear_source_select <= reg_wdata[1:0];
					count_clear_edge_select   <= reg_wdata[5:4];
				end
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data, valid the cycle after the read strobe. The single timer
	// needs no instance select, so index 0 is implicit.
	always @(posedge sys_clk)
	begin
		if (!rst_n)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd)
		begin
			case (reg_addr)
				`REG_CTRL:      reg_rdata <= {31'h0, tmr_enable_setting};
				`REG_TMR_SRC:   reg_rdata <= {22'h0, tmr_launch_edge_select, 3'h0,
				                              tmr_launch_source_select};
				`REG_TMR_LEN:   reg_rdata <= tmr_pulse_length_us;
				`REG_TMR_VAL:   reg_rdata <= tmr_value_reg;
				`REG_TMR_STATE: reg_rdata <= {30'h0, tmr_state_reg};
				`REG_CNT_LIMIT: reg_rdata <= count_end_limit;
				`REG_CNT_VAL:   reg_rdata <= count_value_reg;
				`REG_CNT_SNAP:  reg_rdata <= count_snap_reg;
				`REG_CNT_CFG:   reg_rdata <= {26'h0, count_clear_edge_select,
				                              1'b0, count_run_reg,
				                              count_clear_source_select};
				default:        reg_rdata <= 32'h0000_0000;
			endcase
		end
		else
			reg_rdata <= 32'h0000_0000;
	end

endmodule

// *** tb/event_counter_timer_assertions.sv ***
/*
 * Concurrent checks for the event counter and microsecond timer.
 * Assumes it is bound to the top module and sees only its ports.
 */
`include "evt_tmr_defs.vh"

module event_counter_timer_assertions
(
	// Clock and reset.
	input wire        sys_clk,
	input wire        rst_n,
	// Register port.
	input wire [3:0]  reg_addr,
	input wire [31:0] reg_wdata,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [31:0] reg_rdata,
	// Watched inputs and outputs.
	input wire        broadcast_action_one,
	input wire        input_pin_one,
	input wire        count_inc_evt,
	input wire        tmr_pulse_out,
	input wire        count_end_event,
	input wire        first_tmr_end_event
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	reg        en_q;
	reg [9:0]  src_q;
	reg [31:0] len_q;
	reg [31:0] hi_cnt;

	// Mirror of the timer setup; setup writes only land while disabled.
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			en_q <= 1'b0;
			src_q <= 10'h000;
			len_q <= `TMR_LEN_RST;
			hi_cnt <= 32'h0;
		end
		else
		begin
			hi_cnt <= tmr_pulse_out ? hi_cnt + 32'h1 : 32'h0;
			if (reg_wr && reg_addr == `REG_CTRL)
				en_q <= reg_wdata[`CTRL_TMR_EN];
			if (reg_wr && !en_q && reg_addr == `REG_TMR_SRC)
				src_q <= {reg_wdata[9:8], 3'h0, reg_wdata[4:0]};
			if (reg_wr && !en_q && reg_addr == `REG_TMR_LEN)
				len_q <= reg_wdata;
		end
	end

	// Read data is zero except in the cycle after a read strobe.
	property p_rdata_idle;
		!$past(reg_rd) |-> reg_rdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not zero outside a read answer");

	// The timer end event is a single-cycle pulse.
	property p_end_single;
		first_tmr_end_event |=> !first_tmr_end_event;
	endproperty
	a_end_single: assert property (p_end_single)
		else $error("timer end pulse longer than one cycle");

	// The end event marks the falling edge of the timer output.
	property p_end_falls;
		first_tmr_end_event |-> !tmr_pulse_out && $past(tmr_pulse_out);
	endproperty
	a_end_falls: assert property (p_end_falls)
		else $error("timer end without the output falling");

	// The output never outlasts the programmed number of microseconds.
	property p_pulse_bounded;
		tmr_pulse_out |-> hi_cnt < len_q * `TICK_CYCLES;
	endproperty
	a_pulse_bounded: assert property (p_pulse_bounded)
		else $error("timer output longer than its duration");

	// Once disabled for a full cycle, the output is low.
	property p_disabled_low;
		!en_q && !$past(en_q) |-> !tmr_pulse_out;
	endproperty
	a_disabled_low: assert property (p_disabled_low)
		else $error("timer output high while disabled");

	// The counter end event only follows an increment.
	property p_cnt_end_inc;
		count_end_event |-> $past(count_inc_evt);
	endproperty
	a_cnt_end_inc: assert property (p_cnt_end_inc)
		else $error("counter end without an increment");

	// A self-sourced timer relaunches right after its end event.
	property p_self_relaunch;
		first_tmr_end_event && en_q && src_q[4:0] == `SRC_TMR_END |=> tmr_pulse_out;
	endproperty
	a_self_relaunch: assert property (p_self_relaunch)
		else $error("self-sourced timer did not relaunch");
endmodule

// *** tb/tb_event_counter_timer.sv ***
/*
 * Self-checking bench for the event counter and microsecond timer.
 * Assumes the constants header is on the include path.
 */
`include "evt_tmr_defs.vh"

module tb_event_counter_timer;
	timeunit 1ns;
	timeprecision 1ps;

	// Stimulus: stim[10:0] camera events, stim[11] increment, stim[12] clear.
	logic        sys_clk;
	logic        rst_n;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic [12:0] stim;
	logic [3:0]  cycle_active_set;
	logic        cycle_first_frame;
	logic        pin_one;
	logic        pin_two;
	logic        tmr_pulse_out;
	logic        count_end_event;
	logic        first_tmr_end_event;
	int          err_total;
	int          num_checks;
	int          tmr_ends;
	int          cnt_ends;
	int          hi;
	int          t0;
	logic [31:0] d;
	logic [17:0] rows [0:12];

	event_counter_timer dut
	(
		.sys_clk                (sys_clk),
		.rst_n                  (rst_n),
		.reg_addr               (reg_addr),
		.reg_wdata              (reg_wdata),
		.reg_wr                 (reg_wr),
		.reg_rd                 (reg_rd),
		.reg_rdata              (reg_rdata),
		.acq_start_evt          (stim[0]),
		.acq_end_evt            (stim[1]),
		.exp_start_evt          (stim[2]),
		.exp_end_evt            (stim[3]),
		.rd_start_evt           (stim[4]),
		.rd_end_evt             (stim[5]),
		.frame_start_evt        (stim[6]),
		.accepted_frame_trigger (stim[7]),
		.multi_frame_end_event  (stim[8]),
		.broadcast_action_one   (stim[9]),
		.broadcast_action_two   (stim[10]),
		.cycle_active_set       (cycle_active_set),
		.cycle_first_frame      (cycle_first_frame),
		.count_inc_evt          (stim[11]),
		.count_clear_evt        (stim[12]),
		.input_pin_one          (pin_one),
		.input_pin_two          (pin_two),
		.tmr_pulse_out          (tmr_pulse_out),
		.count_end_event        (count_end_event),
		.first_tmr_end_event    (first_tmr_end_event)
	);

	////////////////////////////////////////////////////////////////////////////
	// Clock: 20 ns period.
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// Count end pulses so scenarios can compare differences.
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			tmr_ends <= 0;
			cnt_ends <= 0;
		end
		else
		begin
			if (first_tmr_end_event)
				tmr_ends <= tmr_ends + 1;
			if (count_end_event)
				cnt_ends <= cnt_ends + 1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// One-cycle write; the edge after the strobe lets the bus idle.
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// One-cycle read; data is taken in the following cycle only.
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask

	// One-cycle pulse on the selected event inputs.
	task automatic pulse(input logic [12:0] m);
		@(posedge sys_clk);
		stim <= m;
		@(posedge sys_clk);
		stim <= 13'h0000;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task end_sim;
		if (err_total == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Arm the timer on one source, fire some events, read the state.
	task automatic run_row(input logic [4:0] src, input logic [10:0] m, input logic [1:0] st);
		wr(`REG_CTRL, 32'h0000_0000);
		wr(`REG_TMR_SRC, {27'h0, src});
		wr(`REG_CTRL, 32'h0000_0001);
		pulse({2'b00, m});
		rd(`REG_TMR_STATE, d);
		check(d, {30'h0, st});
		check({31'h0, tmr_pulse_out}, {31'h0, st == `TST_RUNNING});
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Scenarios.
	initial
	begin
		err_total         = 0;
		num_checks        = 0;
		rst_n             = 1'b0;
		reg_addr          = 4'h0;
		reg_wdata         = 32'h0000_0000;
		reg_wr            = 1'b0;
		reg_rd            = 1'b0;
		stim              = 13'h0000;
		cycle_active_set  = 4'h1;
		cycle_first_frame = 1'b1;
		pin_one           = 1'b0;
		pin_two           = 1'b0;
		rows = '{{`SRC_ACQ_START, 11'h001, `TST_RUNNING}, {`SRC_ACQ_END, 11'h002, `TST_RUNNING},
		         {`SRC_EXP_START, 11'h004, `TST_RUNNING}, {`SRC_EXP_END, 11'h008, `TST_RUNNING},
		         {`SRC_RD_START, 11'h010, `TST_RUNNING}, {`SRC_RD_END, 11'h020, `TST_RUNNING},
		         {`SRC_FRAME_START, 11'h040, `TST_RUNNING},
		         {`SRC_FRAME_TRIG, 11'h080, `TST_RUNNING},
		         {`SRC_BURST_END, 11'h100, `TST_RUNNING},
		         {`SRC_ACTION_ONE, 11'h200, `TST_RUNNING},
		         {`SRC_ACTION_TWO, 11'h400, `TST_RUNNING},
		         {`SRC_CYCLE_FIRST, 11'h040, `TST_RUNNING},
		         {`SRC_ACQ_START, 11'h004, `TST_ARMED}};
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;

		// Reset values.
		rd(`REG_TMR_STATE, d);
		check(d, {30'h0, `TST_IDLE});
		rd(`REG_TMR_LEN, d);
		check(d, `TMR_LEN_RST);
		wr(`REG_TMR_LEN, 32'h0000_0064);

		// Launch cases, one row each; the last row's event must not launch.
		for (int i = 0; i < 13; i++)
			run_row(rows[i][17:13], rows[i][12:2], rows[i][1:0]);

		// Cycling source with another active set must not launch.
		cycle_active_set <= 4'h2;
		run_row(`SRC_CYCLE_FIRST, 11'h040, `TST_ARMED);

		// Source off: the clear command launches a three microsecond pulse.
		wr(`REG_CTRL, 32'h0000_0000);
		wr(`REG_TMR_SRC, {27'h0, `SRC_OFF});
		wr(`REG_TMR_LEN, 32'h0000_0003);
		wr(`REG_CTRL, 32'h0000_0001);
		t0 = tmr_ends;
		hi = 0;
		wr(`REG_CMD, 32'h0000_0001);
		for (int i = 0; i < 400; i++)
		begin
			@(posedge sys_clk);
			#1;
			if (tmr_pulse_out)
				hi++;
		end
		check({31'h0, (hi >= 100 && hi <= 149)}, 32'h1);
		check(tmr_ends - t0, 32'h1);
		rd(`REG_TMR_STATE, d);
		check(d, {30'h0, `TST_DONE});
		rd(`REG_TMR_VAL, d);
		check(d, 32'h0000_0003);

		// Setup is locked while enabled.
		wr(`REG_TMR_LEN, 32'h0000_0007);
		rd(`REG_TMR_LEN, d);
		check(d, 32'h0000_0003);

		// A launch while running is ignored; the clear command rearms.
		wr(`REG_CTRL, 32'h0000_0000);
		wr(`REG_TMR_SRC, {27'h0, `SRC_ACQ_START});
		wr(`REG_TMR_LEN, 32'h0000_0064);
		wr(`REG_CTRL, 32'h0000_0001);
		pulse(13'h0001);
		repeat (120) @(posedge sys_clk);
		pulse(13'h0001);
		rd(`REG_TMR_VAL, d);
		check({31'h0, (d >= 32'h2)}, 32'h1);
		wr(`REG_CMD, 32'h0000_0001);
		rd(`REG_TMR_STATE, d);
		check(d, {30'h0, `TST_ARMED});
		rd(`REG_TMR_VAL, d);
		check(d, 32'h0000_0000);

		// Pin two, falling edge: a rise must not launch, a fall must.
		wr(`REG_CTRL, 32'h0000_0000);
		wr(`REG_TMR_SRC, 32'h0000_010D);
		wr(`REG_CTRL, 32'h0000_0001);
		@(posedge sys_clk);
		pin_two <= 1'b1;
		repeat (6) @(posedge sys_clk);
		rd(`REG_TMR_STATE, d);
		check(d, {30'h0, `TST_ARMED});
		pin_two <= 1'b0;
		repeat (6) @(posedge sys_clk);
		rd(`REG_TMR_STATE, d);
		check(d, {30'h0, `TST_RUNNING});

		// Own end as source: a repeating pulse.
		wr(`REG_CTRL, 32'h0000_0000);
		wr(`REG_TMR_SRC, {27'h0, `SRC_TMR_END});
		wr(`REG_TMR_LEN, 32'h0000_0001);
		wr(`REG_CTRL, 32'h0000_0001);
		t0 = tmr_ends;
		wr(`REG_CMD, 32'h0000_0001);
		repeat (400) @(posedge sys_clk);
		check({31'h0, (tmr_ends - t0 >= 3)}, 32'h1);

		// Counter on its event clear source, limit three.
		wr(`REG_CNT_LIMIT, 32'h0000_0003);
		wr(`REG_CNT_CFG, 32'h0000_0000);
		wr(`REG_CMD, 32'h0000_0002);
		t0 = cnt_ends;
		pulse(13'h0800);
		pulse(13'h0800);
		rd(`REG_CNT_VAL, d);
		check(d, 32'h0000_0002);
		pulse(13'h0800);
		repeat (2) @(posedge sys_clk);
		check(cnt_ends - t0, 32'h1);
		rd(`REG_CNT_VAL, d);
		check(d, 32'h0000_0003);
		pulse(13'h1000);
		rd(`REG_CNT_SNAP, d);
		check(d, 32'h0000_0003);
		pulse(13'h0800);
		rd(`REG_CNT_VAL, d);
		check(d, 32'h0000_0000);
		wr(`REG_CMD, 32'h0000_0002);
		pulse(13'h0800);
		// Pause by holding the event source off.
		repeat (20) @(posedge sys_clk);
		rd(`REG_CNT_VAL, d);
		check(d, 32'h0000_0001);

		// Self-sourced counter wraps and keeps counting.
		wr(`REG_CNT_CFG, 32'h0000_0007);
		wr(`REG_CMD, 32'h0000_0002);
		t0 = cnt_ends;
		pulse(13'h0800);
		pulse(13'h0800);
		pulse(13'h0800);
		rd(`REG_CNT_VAL, d);
		check(d, 32'h0000_0000);
		check(cnt_ends - t0, 32'h1);
		pulse(13'h0800);
		rd(`REG_CNT_VAL, d);
		check(d, 32'h0000_0001);

		// Pin one clears the counter on its falling edge only.
		wr(`REG_CNT_CFG, 32'h0000_0015);
		wr(`REG_CMD, 32'h0000_0002);
		pulse(13'h0800);
		pulse(13'h0800);
		@(posedge sys_clk);
		pin_one <= 1'b1;
		repeat (6) @(posedge sys_clk);
		rd(`REG_CNT_VAL, d);
		check(d, 32'h0000_0002);
		pin_one <= 1'b0;
		repeat (6) @(posedge sys_clk);
		rd(`REG_CNT_VAL, d);
		check(d, 32'h0000_0000);
		rd(`REG_CNT_SNAP, d);
		check(d, 32'h0000_0002);

		// Reset in mid-run drops a running timer.
		cycle_active_set <= 4'h1;
		run_row(`SRC_ACQ_START, 11'h001, `TST_RUNNING);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		#1;
		check({31'h0, tmr_pulse_out}, 32'h0);
		rd(`REG_TMR_STATE, d);
		check(d, {30'h0, `TST_IDLE});
		end_sim();
	end
endmodule

// The checker sees only the top module's ports.
bind event_counter_timer event_counter_timer_assertions u_checks
(
	.sys_clk              (sys_clk),
	.rst_n                (rst_n),
	.reg_addr             (reg_addr),
	.reg_wdata            (reg_wdata),
	.reg_wr               (reg_wr),
	.reg_rd               (reg_rd),
	.reg_rdata            (reg_rdata),
	.broadcast_action_one (broadcast_action_one),
	.input_pin_one        (input_pin_one),
	.count_inc_evt        (count_inc_evt),
	.tmr_pulse_out        (tmr_pulse_out),
	.count_end_event      (count_end_event),
	.first_tmr_end_event  (first_tmr_end_event)
);
